/* rtl/bcrc_unit.sv */
`default_nettype none
// Operation
// - Each input byte write updates stored checksum, except a write into a full queue, which is dropped
// - Update lands one edge after the write; BUSY is high until then
// - Control bit 0 picks CCITT or CRC-16
// - Only the two fixed polynomials exist
// - XOR byte into checksum upper byte
// - Shift left one, zero into LSB
// - Top bit set: XOR 8005H or 1021H
// - Eight shift steps per byte
// - Checksum readable, writable as high/low pair
// - Control bits 7..1 read zero
module bcrc_unit
    import bcrc_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic BUSY
);
    logic [7:0] input_byte_ff;
    logic [15:0] running_checksum_ff;
    logic generator_select_ff;
    logic [7:0] rdata_ff;
    logic busy_ff;
    logic [15:0] nxt_checksum;
    logic [7:0] nxt_rdata;
    logic wr_input;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic fold;
    logic push_in;
    localparam int PW = $clog2(DEPTH) + 1;
    logic [PW-1:0] pending_ff;
    logic [PW-1:0] nxt_pending;

    bcrc_stream_if #(.WIDTH(8)) q_in ();
    bcrc_stream_if #(.WIDTH(8)) q_out ();

    initial
    begin
        if (DEPTH < 2)
            $error("bcrc_unit: DEPTH must be at least 2");
    end

    // Address decode of writes
    assign wr_input = WR && (ADDR == ADDR_INPUT_BYTE);
    assign wr_low = WR && (ADDR == ADDR_CHECKSUM_LOW);
    assign wr_high = WR && (ADDR == ADDR_CHECKSUM_HIGH);
    assign wr_ctrl = WR && (ADDR == ADDR_SELECT_CTRL);

    // Input bytes enter the queue; a full queue drops the byte and no signal flags it
    assign q_in.valid = wr_input;
    assign q_in.data = WDATA;

    bcrc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_queue (
        .clk(CLOCK),
        .rst_n(RST_N),
        .wr(q_in),
        .rd(q_out)
    );

    // One byte folded per clock; stalls while software seeds the pair
    assign fold = q_out.valid && !wr_low && !wr_high;
    assign q_out.ready = fold;

    bcrc_crc_step u_step (
        .sum_in(running_checksum_ff),
        .data_in(q_out.data),
        .select_crc16(generator_select_ff),
        .sum_out(nxt_checksum)
    );

    // Last byte written to the input register, kept for read-back
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            input_byte_ff <= RST_INPUT_BYTE;
        else if (wr_input)
            input_byte_ff <= WDATA;
    end

    // Running checksum: seed writes or byte folds
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            running_checksum_ff <= RST_CHECKSUM;
        else if (wr_low)
            running_checksum_ff[7:0] <= WDATA;
        else if (wr_high)
            running_checksum_ff[15:8] <= WDATA;
        else if (fold)
            running_checksum_ff <= nxt_checksum;
    end

    // Polynomial select bit
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            generator_select_ff <= RST_SELECT;
        else if (wr_ctrl)
            generator_select_ff <= WDATA[SELECT_BIT];
    end

    // Read multiplexer
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (ADDR == ADDR_INPUT_BYTE)
            nxt_rdata = input_byte_ff;
        else if (ADDR == ADDR_CHECKSUM_LOW)
            nxt_rdata = running_checksum_ff[7:0];
        else if (ADDR == ADDR_CHECKSUM_HIGH)
            nxt_rdata = running_checksum_ff[15:8];
        else
            nxt_rdata = {7'h00, generator_select_ff};
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            rdata_ff <= 8'h00;
        else if (RD)
            rdata_ff <= nxt_rdata;
        else
            rdata_ff <= 8'h00;
    end

    // Own count of queued bytes, so no look into the queue's internals is needed
    assign push_in = wr_input && q_in.ready;

    always_comb
    begin
        nxt_pending = pending_ff;
        if (push_in && !fold)
            nxt_pending = pending_ff + 1'b1;
        else if (fold && !push_in)
            nxt_pending = pending_ff - 1'b1;
    end

    // Queued byte count
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            pending_ff <= '0;
        else
            pending_ff <= nxt_pending;
    end

    // Busy while bytes wait to be folded
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            busy_ff <= 1'b0;
        else
            busy_ff <= (nxt_pending != '0);
    end

    assign RDATA = rdata_ff;
    assign BUSY = busy_ff;

    // A single byte into an idle queue lands in the checksum one edge after the write
    fold_latency_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (wr_input && !q_out.valid && pending_ff == '0) ##1 !WR |=>
        running_checksum_ff == $past(nxt_checksum))
        else $error("checksum not updated one cycle after byte");

    fold_update_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        fold |=> running_checksum_ff == $past(nxt_checksum))
        else $error("fold did not store new checksum");

    ctrl_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SELECT_CTRL) |=> rdata_ff[7:1] == 7'h00)
        else $error("control upper bits not zero");

    seed_low_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        wr_low |=> running_checksum_ff[7:0] == $past(WDATA))
        else $error("low seed write lost");

    seed_high_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        wr_high |=> running_checksum_ff[15:8] == $past(WDATA))
        else $error("high seed write lost");

    read_high_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (RD && ADDR == ADDR_CHECKSUM_HIGH) |=> rdata_ff == $past(running_checksum_ff[15:8]))
        else $error("high byte read wrong");

    ccitt_one_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (fold && !generator_select_ff && running_checksum_ff == 16'h0000 && q_out.data == 8'h01)
        |=> running_checksum_ff == 16'h1021)
        else $error("ccitt step for 01h wrong");

    crc16_one_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (fold && generator_select_ff && running_checksum_ff == 16'h0000 && q_out.data == 8'h03)
        |=> running_checksum_ff == 16'h000a)
        else $error("crc16 step for 03h wrong");

    idle_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!fold && !wr_low && !wr_high) |=> $stable(running_checksum_ff))
        else $error("checksum changed without cause");
endmodule : bcrc_unit
`default_nettype wire

/* rtl/bcrc_pkg.sv */
`default_nettype none
package bcrc_pkg;
    // Register indices on the byte-wide register port
    localparam logic [1:0] ADDR_INPUT_BYTE = 2'h0;
    localparam logic [1:0] ADDR_CHECKSUM_LOW = 2'h1;
    localparam logic [1:0] ADDR_CHECKSUM_HIGH = 2'h2;
    localparam logic [1:0] ADDR_SELECT_CTRL = 2'h3;
    // Values after reset
    localparam logic [7:0] RST_INPUT_BYTE = 8'h00;
    localparam logic [15:0] RST_CHECKSUM = 16'h0000;
    localparam logic RST_SELECT = 1'b0;
    // Field position of the polynomial select bit
    localparam int SELECT_BIT = 0;
    // Feedback constants of the two generators
    localparam logic [15:0] GENERATOR_SELECT_CCITT = 16'h1021;
    localparam logic [15:0] GENERATOR_SELECT_CRC16 = 16'h8005;
    // Bit steps per input byte
    localparam int STEPS_PER_BYTE = 8;
    // Depth of the input byte queue
    localparam int QUEUE_DEPTH = 8;
endpackage : bcrc_pkg
`default_nettype wire

/* rtl/bcrc_stream_if.sv */
`default_nettype none
interface bcrc_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : bcrc_stream_if
`default_nettype wire

/* rtl/bcrc_fifo.sv */
`default_nettype none
module bcrc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    bcrc_stream_if.snk wr,
    bcrc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("bcrc_fifo: DEPTH must be a power of two, at least 2");
    end

    // Handshakes on both sides
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    assign wr.ready = (count_ff != (AW + 1)'(DEPTH));
    assign rd.valid = (count_ff != '0);
    assign rd.data = mem_ff[rptr_ff];

    // Storage array, written on push
    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wptr_ff] <= wr.data;
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
                wptr_ff <= wptr_ff + 1'b1;
            if (pop)
                rptr_ff <= rptr_ff + 1'b1;
            if (push && !pop)
                count_ff <= count_ff + 1'b1;
            else if (pop && !push)
                count_ff <= count_ff - 1'b1;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        count_ff <= (AW + 1)'(DEPTH))
        else $error("fifo level beyond depth");
endmodule : bcrc_fifo
`default_nettype wire

/* rtl/bcrc_crc_step.sv */
`default_nettype none
module bcrc_crc_step
    import bcrc_pkg::*;
(
    input wire logic [15:0] sum_in,
    input wire logic [7:0] data_in,
    input wire logic select_crc16,
    output logic [15:0] sum_out
);
    // Folds one byte into the checksum, eight steps unrolled by a loop
    always_comb
    begin
        logic [15:0] tmp;
        logic [15:0] generator_select;
        tmp = '0;
        generator_select = select_crc16 ? GENERATOR_SELECT_CRC16 : GENERATOR_SELECT_CCITT;
        tmp = sum_in ^ {data_in, 8'h00};
        for (int i = 0; i < STEPS_PER_BYTE; i++)
        begin
            if (tmp[15])
                tmp = {tmp[14:0], 1'b0} ^ generator_select;
            else
                tmp = {tmp[14:0], 1'b0};
        end
        sum_out = tmp;
    end
endmodule : bcrc_crc_step
`default_nettype wire

/* verification/bcrc_unit_tb.sv */
`default_nettype none
module bcrc_unit_tb
    import bcrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock;
    logic rst_n;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic busy;
    int err_total;
    int samples_checked;
    integer seed;
    logic [7:0] v;
    logic [7:0] b;
    logic sel;
    logic [15:0] sum;
    logic [15:0] one_tab [2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063, 16'h4084, 16'h50a5, 16'h60c6, 16'h70e7},
        '{16'h0000, 16'h8005, 16'h800f, 16'h000a, 16'h801b, 16'h001e, 16'h0014, 16'h8011}};
    logic [15:0] chain_tab [2][4] = '{'{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa},
        '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43}};
    logic [7:0] chain_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};

    bcrc_unit i_bcrc_unit (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .BUSY(busy));

    // Free-running system clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Reference fold of one byte, MSB first, no reflection
    function automatic logic [15:0] crc_model(input logic [15:0] s, input logic [7:0] d, input logic c16);
        logic [15:0] t;
        logic top;
        t = s ^ {d, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            top = t[15];
            t = {t[14:0], 1'b0};
            if (top)
                t = t ^ (c16 ? 16'h8005 : 16'h1021);
        end
        return t;
    endfunction : crc_model

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // One bus cycle, entered and left at a rising edge
    task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clock);
    endtask : bus

    // Read strobe, data taken in the following cycle only
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] q);
        bus(1'b0, 1'b1, a, 8'h00);
        rd <= 1'b0;
        @(negedge clock);
        q = rdata;
        @(posedge clock);
    endtask : rd_reg

    task automatic wait_idle;
        int n;
        n = 0;
        wr <= 1'b0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (busy !== 1'b0 && n < 40);
        if (busy !== 1'b0)
        begin
            err_total++;
            tally_and_finish;
        end
        @(posedge clock);
    endtask : wait_idle

    task automatic seed_sum(input logic [15:0] s);
        bus(1'b1, 1'b0, ADDR_CHECKSUM_HIGH, s[15:8]);
        bus(1'b1, 1'b0, ADDR_CHECKSUM_LOW, s[7:0]);
    endtask : seed_sum

    task automatic check_sum(input logic [15:0] exp);
        logic [7:0] h;
        logic [7:0] l;
        wait_idle();
        rd_reg(ADDR_CHECKSUM_HIGH, h);
        rd_reg(ADDR_CHECKSUM_LOW, l);
        chk({h, l}, exp);
    endtask : check_sum

    task automatic check_reset;
        for (int a = 0; a < 4; a++)
        begin
            rd_reg(a[1:0], v);
            chk({8'h00, v}, 16'h0000);
        end
    endtask : check_reset

    // Main sequence
    initial
    begin
        err_total = 0;
        samples_checked = 0;
        seed = 72338;
        {wr, rd, addr, wdata} = '0;
        rst_n = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check_reset();
        // Single bytes from a cleared sum, both generators
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, 1'b0, ADDR_SELECT_CTRL, {7'h7f, p[0]});
            rd_reg(ADDR_SELECT_CTRL, v);
            chk({8'h00, v}, {15'h0000, p[0]});
            for (int d = 0; d < 8; d++)
            begin
                seed_sum(16'h0000);
                bus(1'b1, 1'b0, ADDR_INPUT_BYTE, d[7:0]);
                wr <= 1'b0;
                @(negedge clock);
                chk({15'h0000, busy}, 16'h0001);
                check_sum(one_tab[p][d]);
            end
            // Chained bytes, sum kept between writes
            seed_sum(16'h0000);
            for (int i = 0; i < 4; i++)
            begin
                bus(1'b1, 1'b0, ADDR_INPUT_BYTE, chain_in[i]);
                check_sum(chain_tab[p][i]);
            end
        end
        // Seeded start value and input byte readback
        seed_sum(16'ha53c);
        check_sum(16'ha53c);
        bus(1'b1, 1'b0, ADDR_INPUT_BYTE, 8'h5a);
        check_sum(crc_model(16'ha53c, 8'h5a, 1'b1));
        rd_reg(ADDR_INPUT_BYTE, v);
        chk({8'h00, v}, 16'h005a);
        // Random back-to-back bursts through the queue
        for (int r = 0; r < 4; r++)
        begin
            sel = $random(seed);
            sum = $random(seed);
            bus(1'b1, 1'b0, ADDR_SELECT_CTRL, {7'h00, sel});
            seed_sum(sum);
            for (int i = 0; i < 10; i++)
            begin
                b = $random(seed);
                bus(1'b1, 1'b0, ADDR_INPUT_BYTE, b);
                sum = crc_model(sum, b, sel);
            end
            check_sum(sum);
        end
        // Reset in mid-run clears everything again
        bus(1'b1, 1'b0, ADDR_SELECT_CTRL, 8'h01);
        rst_n <= 1'b0;
        wr <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check_reset();
        tally_and_finish();
    end
endmodule : bcrc_unit_tb
`default_nettype wire
